// ==== rtl/fcor_defines.vh ====
// Constants for the flash clock divider and options register block
`ifndef FCOR_DEFINES_VH
`define FCOR_DEFINES_VH

// Register byte addresses
`define FCOR_ADDR_W 4
`define FCOR_OFS_DIV 4'h0
`define FCOR_OFS_OPT 4'h4
`define FCOR_OFS_KEY 4'h8
`define FCOR_OFS_CTL 4'hc

// Divider register fields
`define FCOR_DIV_LOADED 7
`define FCOR_DIV_PRE8 6
`define FCOR_DIV_HI 5
`define FCOR_DIV_LO 0

// Options register fields
`define FCOR_OPT_BACKDOOR_ENABLE 7
`define FCOR_OPT_NORED 6
`define FCOR_OPT_IMPL_MASK 8'hc3
`define FCOR_OPT_SEC_HI 1
`define FCOR_OPT_SEC_LO 0
`define FCOR_SEC_OPEN 2'h2

// Control/status register fields
`define FCOR_CTL_KEYACC 0
`define FCOR_CTL_KEYOK 1
`define FCOR_CTL_SECURE 2
`define FCOR_CTL_ACCERR 4

// Counts
`define FCOR_PRE_LAST 3'h7
`define FCOR_KEY_LAST 3'h7
`define FCOR_KEY_BYTES 8

// Bus answers
`define FCOR_RESP_OKAY 2'h0
`define FCOR_RESP_SLVERR 2'h2

`endif

// ==== rtl/fcor_flash_clock_opts.v ====
// Flash clock divider, options shadow and security state with AXI4-Lite slave
`timescale 1ns/1ns
`include "fcor_defines.vh"

module fcor_flash_clock_opts (
	input wire sys_clk,
	input wire nrst,
	input wire [3:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [3:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire [7:0] nonvolatile_option_byte,
	input wire [7:0] nonvolatile_protection_byte,
	input wire [63:0] stored_unlock_key,
	input wire pe_req,
	input wire blank_check_ok,
	input wire mem_src_unsecured,
	input wire mem_we_in,
	input wire [7:0] mem_rdata_in,
	output reg pe_accept_r,
	output reg flash_tick_r,
	output reg access_error_flag_r,
	output reg secure_r,
	output reg vector_redirect_disable_r,
	output reg [7:0] protection_shadow_r,
	output reg mem_we_r,
	output reg [7:0] mem_rdata_r
);

// --------------------------------------------------------------
// State
// --------------------------------------------------------------
reg divisor_loaded_flag_r;
reg prescale_by_eight_r;
reg [5:0] divisor_r;
reg [7:0] flash_options_shadow_r;
reg [2:0] pre_cnt_r;
reg [5:0] div_cnt_r;
reg key_access_r;
reg [2:0] key_idx_r;
reg key_match_r;
reg key_full_r;
reg key_ok_r;

// --------------------------------------------------------------
// Bus qualifiers and address decode
// --------------------------------------------------------------
wire wr_go = s_axi_awready & s_axi_awvalid & s_axi_wready & s_axi_wvalid;
wire rd_go = s_axi_arready & s_axi_arvalid;
wire lane0 = s_axi_wstrb[0];
// AXI prot bit 1 marks a non-secure master; the background debug port uses it
wire wr_unsecured = s_axi_awprot[1];
wire aw_is_div = (s_axi_awaddr == `FCOR_OFS_DIV);
wire aw_is_opt = (s_axi_awaddr == `FCOR_OFS_OPT);
wire aw_is_key = (s_axi_awaddr == `FCOR_OFS_KEY);
wire aw_is_ctl = (s_axi_awaddr == `FCOR_OFS_CTL);
// Unmapped writes are answered with an error but never touch state
wire wr_map = aw_is_div | aw_is_opt | aw_is_key | aw_is_ctl;
// Lane 0 off: the write is answered OKAY yet changes nothing
wire wr_div = wr_go & lane0 & aw_is_div;
wire wr_key = wr_go & lane0 & aw_is_key;
wire wr_ctl = wr_go & lane0 & aw_is_ctl;
wire [7:0] wbyte = s_axi_wdata[7:0];
// Key byte i sits at bits 8i+7:8i; the index walks them in ascending order
wire [7:0] key_byte = stored_unlock_key[{key_idx_r, 3'h0} +: 8];
wire [1:0] sec_code = flash_options_shadow_r[`FCOR_OPT_SEC_HI:`FCOR_OPT_SEC_LO];
wire pre_tick = ~prescale_by_eight_r | (pre_cnt_r == `FCOR_PRE_LAST);

// --------------------------------------------------------------
// Divider register and flash clock
// --------------------------------------------------------------
always @(posedge sys_clk) begin
	if (!nrst) begin
		divisor_loaded_flag_r <= 1'b0;
		prescale_by_eight_r <= 1'b0;
		divisor_r <= 6'h00;
	end else if (wr_div && !divisor_loaded_flag_r) begin
		// A second value would retune timers that are already running
		// Only the first write lands; the rest are dropped
		divisor_loaded_flag_r <= 1'b1;
		prescale_by_eight_r <= wbyte[`FCOR_DIV_PRE8];
		divisor_r <= wbyte[`FCOR_DIV_HI:`FCOR_DIV_LO];
	end
end

// --------------------------------------------------------------
// Flash clock
// --------------------------------------------------------------
// Prescaler and divisor run only once loaded, so no stray tick precedes setup
always @(posedge sys_clk) begin
	if (!nrst || !divisor_loaded_flag_r) begin
		pre_cnt_r <= 3'h0;
	end else begin
		// Free-running wrap; only its last count matters when prescale is set
		pre_cnt_r <= pre_cnt_r + 3'h1;
	end
end

// Divisor counts prescaler ticks, so the period is divisor plus one inputs
always @(posedge sys_clk) begin
	if (!nrst || !divisor_loaded_flag_r) begin
		div_cnt_r <= 6'h00;
		flash_tick_r <= 1'b0;
	end else begin
		flash_tick_r <= 1'b0;
		if (pre_tick) begin
			if (div_cnt_r >= divisor_r) begin
				div_cnt_r <= 6'h00;
				flash_tick_r <= 1'b1;
			end else begin
				div_cnt_r <= div_cnt_r + 6'h01;
			end
		end
	end
end

// --------------------------------------------------------------
// Program/erase gate and access error
// --------------------------------------------------------------
always @(posedge sys_clk) begin
	if (!nrst) begin
		pe_accept_r <= 1'b0;
		access_error_flag_r <= 1'b0;
	end else begin
		// Accept echoes the request one cycle later, while the request lasts; the sequencer must latch it
		pe_accept_r <= pe_req & divisor_loaded_flag_r;
		if (pe_req && !divisor_loaded_flag_r) begin
			// Set wins over a same-cycle clear
			access_error_flag_r <= 1'b1;
		end else if (wr_ctl && wbyte[`FCOR_CTL_ACCERR]) begin
			access_error_flag_r <= 1'b0;
		end
	end
end

// --------------------------------------------------------------
// Options shadow, protection shadow and security
// --------------------------------------------------------------
always @(posedge sys_clk) begin
	if (!nrst) begin
		// Synchronous reset, so the nonvolatile bytes are loaded here
		flash_options_shadow_r <= nonvolatile_option_byte & `FCOR_OPT_IMPL_MASK;
		protection_shadow_r <= nonvolatile_protection_byte;
	end else if ((key_ok_r && flash_options_shadow_r[`FCOR_OPT_BACKDOOR_ENABLE]) || blank_check_ok) begin
		// No software path writes the shadow; only unlock events touch it
		flash_options_shadow_r[`FCOR_OPT_SEC_HI:`FCOR_OPT_SEC_LO] <= `FCOR_SEC_OPEN;
	end
end

// --------------------------------------------------------------
// Security state and redirection
// --------------------------------------------------------------
// Registered so the security output is glitch-free; it lags the code by a cycle
always @(posedge sys_clk) begin
	if (!nrst) begin
		secure_r <= 1'b1;
		vector_redirect_disable_r <= 1'b0;
	end else begin
		secure_r <= (sec_code != `FCOR_SEC_OPEN);
		vector_redirect_disable_r <= flash_options_shadow_r[`FCOR_OPT_NORED];
	end
end

// --------------------------------------------------------------
// Memory access gate
// --------------------------------------------------------------
// Memory gate: one cycle of latency in exchange for registered outputs
// Judged on the registered secure state, so it opens a cycle after an unlock
always @(posedge sys_clk) begin
	if (!nrst) begin
		mem_we_r <= 1'b0;
		mem_rdata_r <= 8'h00;
	end else if (secure_r && mem_src_unsecured) begin
		mem_we_r <= 1'b0;
		mem_rdata_r <= 8'h00;
	end else begin
		mem_we_r <= mem_we_in;
		mem_rdata_r <= mem_rdata_in;
	end
end

// --------------------------------------------------------------
// Backdoor key entry
// --------------------------------------------------------------
// Bytes must arrive in ascending order; the verdict is taken on key-access exit
// Bytes past the eighth are dropped, and an unfinished key never unlocks
always @(posedge sys_clk) begin
	if (!nrst) begin
		key_access_r <= 1'b0;
		key_idx_r <= 3'h0;
		key_match_r <= 1'b1;
		key_full_r <= 1'b0;
		key_ok_r <= 1'b0;
	end else begin
		key_ok_r <= 1'b0;
		// A debug write to control can neither open nor close key entry
		if (wr_ctl && !wr_unsecured) begin
			key_access_r <= wbyte[`FCOR_CTL_KEYACC];
			if (key_access_r && !wbyte[`FCOR_CTL_KEYACC]) begin
				key_ok_r <= key_full_r & key_match_r;
			end
			if (!key_access_r && wbyte[`FCOR_CTL_KEYACC]) begin
				key_idx_r <= 3'h0;
				key_match_r <= 1'b1;
				key_full_r <= 1'b0;
			end
		end else if (wr_key && key_access_r && !wr_unsecured && !key_full_r) begin
			// Debug-sourced key bytes never reach the compare
			key_match_r <= key_match_r & (wbyte == key_byte);
			key_idx_r <= key_idx_r + 3'h1;
			if (key_idx_r == `FCOR_KEY_LAST) begin
				key_full_r <= 1'b1;
			end
		end
	end
end

// --------------------------------------------------------------
// AXI4-Lite write channel
// --------------------------------------------------------------
// One write in flight: readies wait for both channels, trading speed for a simple slave
always @(posedge sys_clk) begin
	if (!nrst) begin
		s_axi_awready <= 1'b0;
		s_axi_wready <= 1'b0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `FCOR_RESP_OKAY;
	end else begin
		if (wr_go) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_map ? `FCOR_RESP_OKAY : `FCOR_RESP_SLVERR;
		end else if (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
end

// --------------------------------------------------------------
// AXI4-Lite read channel
// --------------------------------------------------------------
// Unmapped offsets read zero and answer with an error
reg [7:0] rd_byte;
reg rd_hit;
always @* begin
	rd_byte = 8'h00;
	rd_hit = 1'b1;
	case (s_axi_araddr)
		`FCOR_OFS_DIV: rd_byte = {divisor_loaded_flag_r, prescale_by_eight_r, divisor_r};
		`FCOR_OFS_OPT: rd_byte = flash_options_shadow_r;
		`FCOR_OFS_KEY: rd_byte = 8'h00;
		`FCOR_OFS_CTL: begin
			rd_byte[`FCOR_CTL_KEYACC] = key_access_r;
			rd_byte[`FCOR_CTL_KEYOK] = key_full_r & key_match_r;
			rd_byte[`FCOR_CTL_SECURE] = secure_r;
			rd_byte[`FCOR_CTL_ACCERR] = access_error_flag_r;
		end
		default: rd_hit = 1'b0;
	endcase
end

// --------------------------------------------------------------
// Read response
// --------------------------------------------------------------
// Arready waits for rvalid to clear, so at most one read is open
always @(posedge sys_clk) begin
	if (!nrst) begin
		s_axi_arready <= 1'b0;
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h00000000;
		s_axi_rresp <= `FCOR_RESP_OKAY;
	end else begin
		if (rd_go) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h000000, rd_byte};
			s_axi_rresp <= rd_hit ? `FCOR_RESP_OKAY : `FCOR_RESP_SLVERR;
		end else if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
			s_axi_arready <= 1'b1;
		end
		if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
end

endmodule

// ==== tb/fcor_nvm_model.sv ====
// Nonvolatile option, protection and key image seen by the block at reset
`timescale 1ns/1ns
module fcor_nvm_model #(
	parameter [63:0] KEY = 64'h0f1e2d3c4b5a6978
) (
	input wire [1:0] image_sel,
	output logic [7:0] nonvolatile_option_byte,
	output wire [7:0] nonvolatile_protection_byte,
	output wire [63:0] stored_unlock_key
);
	// Four images cover every security code; option bits change only by a new image and reset
	always_comb begin
		case (image_sel)
			2'h0: nonvolatile_option_byte = 8'hbf;
			2'h1: nonvolatile_option_byte = 8'h7e;
			2'h2: nonvolatile_option_byte = 8'h41;
			default: nonvolatile_option_byte = 8'h00;
		endcase
	end
	assign nonvolatile_protection_byte = {nonvolatile_option_byte[3:0], nonvolatile_option_byte[7:4]};
	assign stored_unlock_key = KEY;
endmodule

// ==== tb/fcor_checker_sva.sv ====
// Port checker for the flash clock divider and options block
`timescale 1ns/1ns
module fcor_checker (
	input wire sys_clk,
	input wire nrst,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire pe_req,
	input wire mem_src_unsecured,
	input wire mem_we_in,
	input wire [7:0] mem_rdata_in,
	input wire pe_accept_r,
	input wire access_error_flag_r,
	input wire secure_r,
	input wire mem_we_r,
	input wire [7:0] mem_rdata_r
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	sequence wr_hs;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_hs;
		s_axi_arvalid && s_axi_arready;
	endsequence
	wr_resp_a: assert property (wr_hs |=> s_axi_bvalid) else $error("write response missing");
	rd_resp_a: assert property (rd_hs |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
		else $error("read answer late or wide");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	accept_cause_a: assert property (pe_accept_r |-> $past(pe_req)) else $error("accept without request");
	err_cause_a: assert property ($rose(access_error_flag_r) |-> $past(pe_req)) else $error("stray error");
	mem_block_a: assert property (secure_r && mem_src_unsecured |=> !mem_we_r && mem_rdata_r == 8'h00)
		else $error("secure memory leaked");
	mem_pass_a: assert property (!secure_r |=> mem_we_r == $past(mem_we_in) && mem_rdata_r == $past(mem_rdata_in))
		else $error("open memory access altered");
endmodule
bind fcor_flash_clock_opts fcor_checker chk (.*);

// ==== tb/fcor_flash_clock_opts_tb_top.sv ====
// Self-checking bench for the flash clock divider and options block
`timescale 1ns/1ns
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin n_errors++; $display("ERROR %s exp %h got %h", nm, e, s); end end
module fcor_flash_clock_opts_tb_top;
	logic sys_clk = 0, nrst = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, pe_req = 0, blank_check_ok = 0, mem_src_unsecured = 0, mem_we_in = 1;
	logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
	logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
	logic [31:0] s_axi_wdata = 0;
	logic [7:0] mem_rdata_in = 8'h00, d;
	logic [1:0] image_sel = 0, rsp = 0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pe_accept_r, flash_tick_r;
	wire access_error_flag_r, secure_r, vector_redirect_disable_r, mem_we_r;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [7:0] nonvolatile_option_byte, nonvolatile_protection_byte, protection_shadow_r, mem_rdata_r;
	wire [63:0] stored_unlock_key;
	int n_errors = 0, n_compared = 0, k;
	fcor_flash_clock_opts dut (.*);
	fcor_nvm_model nvm (.*);
	initial forever #25 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		mem_rdata_in <= mem_rdata_in + 8'h01;
		mem_src_unsecured <= ~mem_src_unsecured;
		mem_we_in <= mem_rdata_in[1];
	end
	task tally_and_finish;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task lim(input int i);
		if (i >= 3000) begin
			n_errors++;
			$display("ERROR wait exp done got timeout");
			tally_and_finish;
		end
	endtask
	// ----------------------------------------
	// Bus and reset helpers
	// ----------------------------------------
	task wr(input [3:0] a, input [7:0] v, input [2:0] p);
		int i;
		s_axi_awaddr <= a;
		s_axi_awprot <= p;
		s_axi_wdata <= {24'h0, v};
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		for (i = 0; i < 3000; i++) begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			// Ready follows the answer by a cycle, so the slave must hold it
			if (s_axi_bvalid && s_axi_bready) break;
			if (s_axi_bvalid) s_axi_bready <= 1;
		end
		rsp = s_axi_bresp;
		s_axi_bready <= 0;
		lim(i);
	endtask
	task rd(input [3:0] a);
		int i;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		for (i = 0; i < 3000; i++) begin
			@(posedge sys_clk);
			if (s_axi_arready) s_axi_arvalid <= 0;
			if (s_axi_rvalid && s_axi_rready) break;
			if (s_axi_rvalid) s_axi_rready <= 1;
		end
		d = s_axi_rdata[7:0];
		rsp = s_axi_rresp;
		s_axi_rready <= 0;
		lim(i);
	endtask
	task rst(input [1:0] img);
		nrst <= 0;
		image_sel <= img;
		repeat (20) @(posedge sys_clk);
		nrst <= 1;
		repeat (2) @(posedge sys_clk);
	endtask
	task pulse_pe(input acc, input err);
		pe_req <= 1;
		@(posedge sys_clk);
		pe_req <= 0;
		@(negedge sys_clk);
		`CHK("pe accept", acc, pe_accept_r)
		`CHK("pe error", err, access_error_flag_r)
		@(posedge sys_clk);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_reset(input [1:0] img, input [7:0] ro, input sec);
		rst(img);
		rd(4'h0);
		`CHK("divider", 8'h00, d)
		wr(4'h4, 8'hff, 3'h0);
		rd(4'h4);
		`CHK("options", ro, d)
		`CHK("secure", sec, secure_r)
		`CHK("redirect", ro[6], vector_redirect_disable_r)
		`CHK("prot", nonvolatile_protection_byte, protection_shadow_r)
		$display("reset image %0d done", img);
	endtask
	task t_div(input [7:0] dv, input int per);
		int i, n;
		rst(2'h1);
		pulse_pe(1'b0, 1'b1);
		// Request held across the clear, so set and clear meet in one cycle
		pe_req <= 1;
		wr(4'hc, 8'h10, 3'h0);
		pe_req <= 0;
		rd(4'hc);
		`CHK("error set wins", 1'b1, d[4])
		s_axi_wstrb <= 4'he;
		wr(4'h0, dv, 3'h0);
		s_axi_wstrb <= 4'hf;
		rd(4'h0);
		`CHK("lane off", 8'h00, d)
		wr(4'h0, dv, 3'h0);
		rd(4'h0);
		`CHK("loaded", {1'b1, dv[6:0]}, d)
		wr(4'h0, ~dv, 3'h0);
		rd(4'h0);
		`CHK("rewrite", {1'b1, dv[6:0]}, d)
		pulse_pe(1'b1, 1'b1);
		wr(4'hc, 8'h10, 3'h0);
		rd(4'hc);
		`CHK("error clear", 1'b0, d[4])
		for (i = 0; i < 3000 && flash_tick_r !== 1'b1; i++) @(posedge sys_clk);
		lim(i);
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (flash_tick_r !== 1'b1 && n < 3000);
		lim(n);
		`CHK("tick period", per, n)
		$display("divider %h done", dv);
	endtask
	task t_key(input [1:0] img, input [2:0] p, input [63:0] key, input sec);
		rst(img);
		wr(4'hc, 8'h01, p);
		for (k = 0; k < 8; k++) wr(4'h8, key[8*k+:8], p);
		wr(4'hc, 8'h00, p);
		repeat (8) @(posedge sys_clk);
		`CHK("key secure", sec, secure_r)
		$display("key entry image %0d prot %0d done", img, p);
	endtask
	task t_map;
		rst(2'h1);
		wr(4'h2, 8'h5a, 3'h0);
		`CHK("unmapped write resp", 2'h2, rsp)
		rd(4'h6);
		`CHK("unmapped read resp", 2'h2, rsp)
		`CHK("unmapped read data", 8'h00, d)
		rd(4'h0);
		`CHK("mapped read resp", 2'h0, rsp)
		`CHK("unmapped write effect", 8'h00, d)
		$display("address map done");
	endtask
	task t_blank;
		rst(2'h0);
		blank_check_ok <= 1;
		@(posedge sys_clk);
		blank_check_ok <= 0;
		repeat (4) @(posedge sys_clk);
		`CHK("blank secure", 1'b0, secure_r)
		$display("blank check done");
	endtask
	initial begin
		t_reset(2'h0, 8'h83, 1'b1);
		t_reset(2'h1, 8'h42, 1'b0);
		t_reset(2'h2, 8'h41, 1'b1);
		t_reset(2'h3, 8'h00, 1'b1);
		t_div(8'h4c, 104);
		t_div(8'h05, 6);
		t_key(2'h0, 3'h2, stored_unlock_key, 1'b1);
		t_key(2'h0, 3'h0, stored_unlock_key ^ 64'h1, 1'b1);
		t_key(2'h2, 3'h0, stored_unlock_key, 1'b1);
		t_key(2'h0, 3'h0, stored_unlock_key, 1'b0);
		t_blank;
		t_map;
		tally_and_finish;
	end
endmodule
